// ---- src/crs_pkg.sv ----
// Purpose: constants shared by the return/rotate/subtract/sleep execution unit
// Assumes: 100 MHz aclk, axi4-lite register access, 16-bit instruction word
// Notes:   offsets are byte addresses of aligned 32-bit words
package crs_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_INSTR  = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_WREG   = 8'h08;
   localparam logic [7:0] OFF_PC     = 8'h0C;

   // instruction word fields
   localparam int INS_OP_LSB = 10;
   localparam int INS_OP_MSB = 15;
   localparam int INS_D_BIT  = 8;

   // operation codes
   localparam logic [5:0] OP_NONE   = 6'h00;
   localparam logic [5:0] OP_RETLIT = 6'h01;
   localparam logic [5:0] OP_RETURN = 6'h02;
   localparam logic [5:0] OP_ROTR   = 6'h03;
   localparam logic [5:0] OP_SLEEP  = 6'h04;
   localparam logic [5:0] OP_SUBL   = 6'h05;
   localparam logic [5:0] OP_SUBF   = 6'h06;

   // status register bit positions
   localparam int ST_C        = 0;
   localparam int ST_HC       = 1;
   localparam int ST_Z        = 2;
   localparam int ST_PWDN     = 3;
   localparam int ST_EXP      = 4;
   localparam int ST_SLEEPING = 5;
   localparam int ST_BUSY     = 6;

   // reset values
   localparam logic [7:0]  W_RST      = 8'h00;
   localparam logic [15:0] INSTR_RST  = 16'h0000;
   localparam logic        PWDN_RST   = 1'b0;
   localparam logic        TO_RST     = 1'b1;

   // destination select
   localparam logic DEST_W    = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one-hot sequencer states
   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_EXEC  = 5'b00010,
      S_RET2  = 5'b00100,
      S_SLEEP = 5'b01000,
      S_WAKE  = 5'b10000
   } crs_fsm_e;

endpackage

// ---- src/crs_core.sv ----
// Purpose: executes no-op, return-with-literal, return, rotate right, sleep, two subtracts
// Assumes: file_rdata is valid in the cycle file_addr is shown (asynchronous-read file)
// Notes:   instructions are issued by writing the instruction register over axi4-lite
//
// Operation
// - no-operation changes nothing and lasts exactly one instruction cycle
// - return-with-literal loads literal into W, reloads PC from stack, pops; two cycles
// - return reloads PC from top of stack, then pops; two cycles, flags unchanged
// - destination bit 0 writes W, 1 writes back the addressed file register
// - rotate right through carry: old carry to bit 7, bit 0 to carry
// - sleep stops the oscillator in one cycle, unlike halt stopping core clock
// - after sleep, resume only on external interrupt or watchdog wake-up
// - sleep sets power-down, clears expiry; watchdog wake-up sets expiry
// - subtract-from-literal: literal minus W into W, updates carry, half carry, zero
// - subtract-from-file: file minus W to chosen destination, updates same flags
`timescale 1ns/100ps
`default_nettype none
module crs_core #(
   parameter int ADDR_W = 8,
   parameter int PC_W   = 11
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   output logic [7:0]             file_addr,
   input  wire logic [7:0]        file_rdata,
   output logic [7:0]             file_wdata,
   output logic                   file_we,
   input  wire logic [PC_W-1:0]   stack_top,
   output logic                   stack_pop,
   output logic [PC_W-1:0]        pc,
   output logic                   osc_run,
   input  wire logic              ext_wake,
   input  wire logic              wdt_wake
);

   typedef struct packed {
      crs_pkg::crs_fsm_e fsm;
      logic [15:0]       instr;
      logic [7:0]        w;
      logic              c;
      logic              hc;
      logic              z;
      logic              pwdn;
      logic              to;
      logic [PC_W-1:0]   pc;
      logic [7:0]        file_addr;
      logic [7:0]        file_wdata;
      logic              file_we;
      logic              stack_pop;
      logic              osc_run;
      logic              aw_rdy;
      logic              aw_got;
      logic [ADDR_W-1:0] awaddr;
      logic              w_rdy;
      logic              w_got;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              ar_rdy;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } crs_state_s;

   crs_state_s st;
   crs_state_s nx;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      addr_hit = (a == ADDR_W'(off));
   endfunction

   function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      strb_merge = (old & ~m) | (nw & m);
   endfunction

   function automatic logic op_legal(input logic [5:0] op);
      op_legal = (op == crs_pkg::OP_NONE) || (op == crs_pkg::OP_RETLIT) ||
                 (op == crs_pkg::OP_RETURN) || (op == crs_pkg::OP_ROTR) ||
                 (op == crs_pkg::OP_SLEEP) || (op == crs_pkg::OP_SUBL) ||
                 (op == crs_pkg::OP_SUBF);
   endfunction

   logic [5:0]  cur_op;
   logic        cur_d;
   logic [7:0]  cur_lit;
   logic [7:0]  sub_a;
   logic [8:0]  sub_full;
   logic [4:0]  sub_low;
   logic [31:0] status_word;
   logic [31:0] wr_merged;

   assign cur_op  = st.instr[crs_pkg::INS_OP_MSB:crs_pkg::INS_OP_LSB];
   assign cur_d   = st.instr[crs_pkg::INS_D_BIT];
   assign cur_lit = st.instr[7:0];
   // minuend: literal for the literal form, file operand otherwise
   assign sub_a    = (cur_op == crs_pkg::OP_SUBL) ? cur_lit : file_rdata;
   // a + ~w + 1: bit 8 and bit 4 are the no-borrow outputs
   assign sub_full = {1'b0, sub_a} + {1'b0, ~st.w} + 9'h001;
   assign sub_low  = {1'b0, sub_a[3:0]} + {1'b0, ~st.w[3:0]} + 5'h01;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[crs_pkg::ST_C]        = st.c;
      status_word[crs_pkg::ST_HC]       = st.hc;
      status_word[crs_pkg::ST_Z]        = st.z;
      status_word[crs_pkg::ST_PWDN]     = st.pwdn;
      status_word[crs_pkg::ST_EXP]      = st.to;
      status_word[crs_pkg::ST_SLEEPING] = (st.fsm == crs_pkg::S_SLEEP);
      status_word[crs_pkg::ST_BUSY]     = (st.fsm != crs_pkg::S_IDLE);
   end

   always_comb begin
      nx = st;
      wr_merged = 32'h0000_0000;
      nx.file_we   = 1'b0;
      nx.stack_pop = 1'b0;

      // sequencer
      case (st.fsm)
         crs_pkg::S_IDLE: begin
         end
         crs_pkg::S_EXEC: begin
            nx.fsm = crs_pkg::S_IDLE;
            case (cur_op)
               crs_pkg::OP_NONE: begin
                  // single cycle, nothing touched
               end
               crs_pkg::OP_RETLIT: begin
                  nx.w   = cur_lit;
                  nx.pc  = stack_top;
                  nx.fsm = crs_pkg::S_RET2;
               end
               crs_pkg::OP_RETURN: begin
                  nx.pc  = stack_top;
                  nx.fsm = crs_pkg::S_RET2;
               end
               crs_pkg::OP_ROTR: begin
                  nx.c = file_rdata[0];
                  if (cur_d == crs_pkg::DEST_W) begin
                     nx.w = {st.c, file_rdata[7:1]};
                  end else begin
                     nx.file_wdata = {st.c, file_rdata[7:1]};
                     nx.file_we    = 1'b1;
                  end
               end
               crs_pkg::OP_SLEEP: begin
                  nx.osc_run = 1'b0;
                  nx.pwdn    = 1'b1;
                  nx.to      = 1'b0;
                  nx.fsm     = crs_pkg::S_SLEEP;
               end
               crs_pkg::OP_SUBL, crs_pkg::OP_SUBF: begin
                  nx.c  = sub_full[8];
                  nx.hc = sub_low[4];
                  nx.z  = (sub_full[7:0] == 8'h00);
                  if (cur_op == crs_pkg::OP_SUBL || cur_d == crs_pkg::DEST_W) begin
                     nx.w = sub_full[7:0];
                  end else begin
                     nx.file_wdata = sub_full[7:0];
                     nx.file_we    = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
         crs_pkg::S_RET2: begin
            nx.stack_pop = 1'b1;
            nx.fsm       = crs_pkg::S_IDLE;
         end
         crs_pkg::S_SLEEP: begin
            // only a wake source ends sleep; writes are refused meanwhile
            if (ext_wake || wdt_wake) begin
               nx.osc_run = 1'b1;
               nx.to      = wdt_wake;
               nx.fsm     = crs_pkg::S_WAKE;
            end
         end
         crs_pkg::S_WAKE: begin
            nx.fsm = crs_pkg::S_IDLE;
         end
         default: begin
            nx.fsm = crs_pkg::S_IDLE;
         end
      endcase

      // axi write: address and data taken in either order
      if (s_axi_awvalid && st.aw_rdy) begin
         nx.aw_rdy = 1'b0;
         nx.aw_got = 1'b1;
         nx.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.w_rdy) begin
         nx.w_rdy = 1'b0;
         nx.w_got = 1'b1;
         nx.wdata = s_axi_wdata;
         nx.wstrb = s_axi_wstrb;
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
         nx.aw_got = 1'b0;
         nx.w_got  = 1'b0;
         nx.bvalid = 1'b1;
         nx.bresp  = crs_pkg::RESP_OKAY;
         if (st.fsm != crs_pkg::S_IDLE) begin
            // busy or asleep: nothing may change under a running instruction
            nx.bresp = crs_pkg::RESP_SLVERR;
         end else if (addr_hit(st.awaddr, crs_pkg::OFF_INSTR)) begin
            wr_merged = strb_merge({16'h0000, st.instr}, st.wdata, st.wstrb);
            if (op_legal(wr_merged[crs_pkg::INS_OP_MSB:crs_pkg::INS_OP_LSB])) begin
               nx.instr     = wr_merged[15:0];
               nx.file_addr = wr_merged[7:0];
               nx.fsm       = crs_pkg::S_EXEC;
            end else begin
               nx.bresp = crs_pkg::RESP_SLVERR;
            end
         end else if (addr_hit(st.awaddr, crs_pkg::OFF_WREG)) begin
            wr_merged = strb_merge({24'h000000, st.w}, st.wdata, st.wstrb);
            nx.w = wr_merged[7:0];
         end else if (addr_hit(st.awaddr, crs_pkg::OFF_STATUS)) begin
            // only the arithmetic flags are writable; power-down and expiry are not
            wr_merged = strb_merge(status_word, st.wdata, st.wstrb);
            nx.c  = wr_merged[crs_pkg::ST_C];
            nx.hc = wr_merged[crs_pkg::ST_HC];
            nx.z  = wr_merged[crs_pkg::ST_Z];
         end else begin
            nx.bresp = crs_pkg::RESP_SLVERR;
         end
      end
      if (st.bvalid && s_axi_bready) begin
         nx.bvalid = 1'b0;
         nx.aw_rdy = 1'b1;
         nx.w_rdy  = 1'b1;
      end

      // axi read
      if (s_axi_arvalid && st.ar_rdy) begin
         nx.ar_rdy = 1'b0;
         nx.rvalid = 1'b1;
         nx.rresp  = crs_pkg::RESP_OKAY;
         nx.rdata  = 32'h0000_0000;
         if (addr_hit(s_axi_araddr, crs_pkg::OFF_INSTR)) begin
            nx.rdata = {16'h0000, st.instr};
         end else if (addr_hit(s_axi_araddr, crs_pkg::OFF_STATUS)) begin
            nx.rdata = status_word;
         end else if (addr_hit(s_axi_araddr, crs_pkg::OFF_WREG)) begin
            nx.rdata = {24'h000000, st.w};
         end else if (addr_hit(s_axi_araddr, crs_pkg::OFF_PC)) begin
            nx.rdata = 32'(st.pc);
         end else begin
            nx.rresp = crs_pkg::RESP_SLVERR;
         end
      end
      if (st.rvalid && s_axi_rready) begin
         nx.rvalid = 1'b0;
         nx.ar_rdy = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st         <= '0;
         st.fsm     <= crs_pkg::S_IDLE;
         st.instr   <= crs_pkg::INSTR_RST;
         st.w       <= crs_pkg::W_RST;
         st.pwdn    <= crs_pkg::PWDN_RST;
         st.to      <= crs_pkg::TO_RST;
         st.osc_run <= 1'b1;
         st.aw_rdy  <= 1'b1;
         st.w_rdy   <= 1'b1;
         st.ar_rdy  <= 1'b1;
      end else if (ce) begin
         st <= nx;
      end
   end

   assign s_axi_awready = st.aw_rdy;
   assign s_axi_wready  = st.w_rdy;
   assign s_axi_bvalid  = st.bvalid;
   assign s_axi_bresp   = st.bresp;
   assign s_axi_arready = st.ar_rdy;
   assign s_axi_rvalid  = st.rvalid;
   assign s_axi_rdata   = st.rdata;
   assign s_axi_rresp   = st.rresp;
   assign file_addr     = st.file_addr;
   assign file_wdata    = st.file_wdata;
   assign file_we       = st.file_we;
   assign stack_pop     = st.stack_pop;
   assign pc            = st.pc;
   assign osc_run       = st.osc_run;

   // checks hold while ce stays high; a frozen cycle suspends them
   logic       ex_nop;
   logic       ex_ret;
   logic       ex_rrf;
   logic       ex_sleep;
   logic       ex_subtract_acc_from_literal;
   logic       ex_subtract_acc_from_file;
   logic [4:0] flag_vec;
   logic [7:0] cur_w;
   logic       cur_c;

   assign ex_nop   = (st.fsm == crs_pkg::S_EXEC) && (cur_op == crs_pkg::OP_NONE);
   assign ex_ret   = (st.fsm == crs_pkg::S_EXEC) &&
                     (cur_op == crs_pkg::OP_RETLIT || cur_op == crs_pkg::OP_RETURN);
   assign ex_rrf   = (st.fsm == crs_pkg::S_EXEC) && (cur_op == crs_pkg::OP_ROTR);
   assign ex_sleep = (st.fsm == crs_pkg::S_EXEC) && (cur_op == crs_pkg::OP_SLEEP);
   assign ex_subtract_acc_from_literal = (st.fsm == crs_pkg::S_EXEC) && (cur_op == crs_pkg::OP_SUBL);
   assign ex_subtract_acc_from_file = (st.fsm == crs_pkg::S_EXEC) && (cur_op == crs_pkg::OP_SUBF);
   assign flag_vec = {st.c, st.hc, st.z, st.pwdn, st.to};
   assign cur_w    = st.w;
   assign cur_c    = st.c;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn || !ce);

   sequence s_ret_steps;
      ##1 (st.fsm == crs_pkg::S_RET2 && !stack_pop) ##1 (stack_pop && st.fsm == crs_pkg::S_IDLE);
   endsequence

   property p_nop;
      ex_nop |=> $stable(cur_w) && $stable(flag_vec) && !file_we && st.fsm == crs_pkg::S_IDLE;
   endproperty
   a_nop: assert property (p_nop) else $error("no-operation changed state");

   property p_ret;
      ex_ret |-> s_ret_steps;
   endproperty
   a_ret: assert property (p_ret) else $error("return sequence wrong");

   property p_ret_pc;
      ex_ret |=> pc == $past(stack_top) && $stable(flag_vec);
   endproperty
   a_ret_pc: assert property (p_ret_pc) else $error("pc not reloaded from stack");

   property p_rrf;
      ex_rrf && !cur_d |=> cur_w == {$past(cur_c), $past(file_rdata[7:1])} &&
                           cur_c == $past(file_rdata[0]);
   endproperty
   a_rrf: assert property (p_rrf) else $error("rotate result wrong");

   property p_dest_file;
      (ex_rrf || ex_subtract_acc_from_file) && cur_d |=> file_we && $stable(cur_w);
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("destination not file");

   property p_sleep;
      ex_sleep |=> !osc_run && st.pwdn && !st.to && st.fsm == crs_pkg::S_SLEEP;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry wrong");

   property p_stay_asleep;
      st.fsm == crs_pkg::S_SLEEP && !ext_wake && !wdt_wake |=> !osc_run;
   endproperty
   a_stay_asleep: assert property (p_stay_asleep) else $error("woke without source");

   property p_wdt_wake;
      st.fsm == crs_pkg::S_SLEEP && wdt_wake |=> osc_run && st.to ##1 st.fsm == crs_pkg::S_IDLE;
   endproperty
   a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake flags wrong");

   property p_subtract_acc_from_literal;
      ex_subtract_acc_from_literal |=> cur_w == 8'($past(cur_lit) - $past(cur_w)) &&
                   cur_c == ($past(cur_lit) >= $past(cur_w)) && st.z == (cur_w == 8'h00);
   endproperty
   a_subtract_acc_from_literal: assert property (p_subtract_acc_from_literal) else $error("literal subtract wrong");

   property p_subtract_acc_from_file;
      ex_subtract_acc_from_file && !cur_d |=> cur_w == 8'($past(file_rdata) - $past(cur_w)) &&
                             cur_c == ($past(file_rdata) >= $past(cur_w));
   endproperty
   a_subtract_acc_from_file: assert property (p_subtract_acc_from_file) else $error("file subtract wrong");

endmodule
`default_nettype wire

// ---- tb/crs_far_model.sv ----
// Purpose: far-side model holding the file registers and the return stack
// Assumes: asynchronous file read, four-entry stack filled by the bench
// Notes:   an empty stack shows inverted old data, never a stale good value
`timescale 1ns/100ps
`default_nettype none
module crs_far_model (
   input  wire logic        aclk,
   input  wire logic [7:0]  file_addr,
   output logic      [7:0]  file_rdata,
   input  wire logic [7:0]  file_wdata,
   input  wire logic        file_we,
   output logic      [10:0] stack_top,
   input  wire logic        stack_pop,
   input  wire logic        push_en,
   input  wire logic [10:0] push_val
);
   logic [7:0]  mem [256];
   logic [10:0] stk [4];
   int          sp = 0;

   assign file_rdata = mem[file_addr];
   assign stack_top  = (sp == 0) ? ~stk[0] : stk[sp - 1];

   always @(posedge aclk) begin
      if (file_we)
         mem[file_addr] <= file_wdata;
      if (push_en) begin
         stk[sp] <= push_val;
         sp <= sp + 1;
      end else if (stack_pop && sp > 0)
         sp <= sp - 1;
   end
endmodule
`default_nettype wire

// ---- tb/test_crs_core.sv ----
// Purpose: self-checking bench for the execution unit
// Assumes: fixed seed, axi4-lite master tasks, far-side model
// Notes:   ce held high, so clock-enable stalls are not exercised
`timescale 1ns/100ps
`default_nettype none
module test_crs_core;
   logic        aclk = 0;
   logic        aresetn = 0;
   logic        ce = 1;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, file_we, stack_pop, osc_run;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0]  file_addr, file_rdata, file_wdata;
   logic [10:0] stack_top, pc;
   logic [10:0] push_val = '0;
   logic        push_en = 0, ext_wake = 0, wdt_wake = 0, bv_q = 0, osc_q = 1;
   int          error_cnt = 0, cmp_count = 0;
   int          cyc = 0, t_b = 0, t_we = 0, t_pop = 0, t_osc = 0;

   initial forever #5 aclk = ~aclk;

   crs_core i_dut (
      .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .file_addr, .file_rdata, .file_wdata, .file_we, .stack_top,
      .stack_pop, .pc, .osc_run, .ext_wake, .wdt_wake
   );
   crs_far_model i_far (
      .aclk, .file_addr, .file_rdata, .file_wdata, .file_we, .stack_top, .stack_pop,
      .push_en, .push_val
   );

   // cycle stamps, so latencies are measured from the issuing write
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      bv_q <= s_axi_bvalid;
      osc_q <= osc_run;
      if (s_axi_bvalid && !bv_q)
         t_b <= cyc;
      if (file_we)
         t_we <= cyc;
      if (stack_pop)
         t_pop <= cyc;
      if (!osc_run && osc_q)
         t_osc <= cyc;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      r = 2'h3;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 0;
            return;
         end
      end
      error_cnt++;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (int n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 0;
            return;
         end
      end
      error_cnt++;
   endtask

   task automatic idle();
      logic [31:0] s;
      logic [1:0]  q;
      for (int n = 0; n < 20; n++) begin
         rd(crs_pkg::OFF_STATUS, s, q);
         if (s[crs_pkg::ST_BUSY] === 1'b0)
            break;
      end
   endtask

   task automatic ex(input logic [5:0] op, input logic dd, input logic [7:0] f);
      logic [1:0] q;
      wr(crs_pkg::OFF_INSTR, {16'h0, op, 1'b0, dd, f}, q);
      idle();
   endtask

   task automatic setws(input logic [7:0] w, input logic [2:0] s);
      logic [1:0] q;
      wr(crs_pkg::OFF_WREG, {24'h0, w}, q);
      wr(crs_pkg::OFF_STATUS, {29'h0, s}, q);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  q;
      rd(a, v, q);
      chk(nm, v & m, e);
   endtask

   task automatic push(input logic [10:0] v);
      @(posedge aclk);
      push_en <= 1;
      push_val <= v;
      @(posedge aclk);
      push_en <= 0;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      summarize();
   end

   initial begin
      logic [1:0]  r;
      logic [7:0]  w, k, fv, a, res;
      logic [7:0]  cf [3] = '{8'h33, 8'h01, 8'h04};
      logic [7:0]  cw [3] = '{8'h01, 8'h01, 8'h05};
      logic [2:0]  s3;
      logic [5:0]  op;
      logic [10:0] pv;
      logic        dd;
      int          tw, tp, n;
      void'($urandom(32'h364D2A81));
      repeat (5) @(posedge aclk);
      aresetn <= 1;
      rdchk("reset status", crs_pkg::OFF_STATUS, 32'h7F, 32'h10);
      rdchk("reset w", crs_pkg::OFF_WREG, 32'hFF, 32'h0);
      wr(8'h40, 32'h0, r);
      chk("unmapped write", r, crs_pkg::RESP_SLVERR);
      wr(crs_pkg::OFF_INSTR, 32'hFC00, r);
      chk("bad opcode", r, crs_pkg::RESP_SLVERR);
      $display("test reset done");
      // even passes literal form, odd passes file form
      for (int i = 0; i < 24; i++) begin
         op = i[0] ? crs_pkg::OP_SUBF : crs_pkg::OP_SUBL;
         dd = i[0] && (i < 6 || $urandom % 2);
         a = 8'($urandom);
         fv = i < 6 ? cf[i / 2] : 8'($urandom);
         w = i < 6 ? cw[i / 2] : 8'($urandom);
         i_far.mem[a] = fv;
         setws(w, 3'h0);
         ex(op, dd, i[0] ? a : fv);
         res = fv - w;
         rdchk("sub w", crs_pkg::OFF_WREG, 32'hFF, dd ? w : res);
         chk("sub file", i_far.mem[a], dd ? res : fv);
         rdchk("sub flags", crs_pkg::OFF_STATUS, 32'h7, {res == 0, fv[3:0] >= w[3:0], fv >= w});
         if (dd)
            chk("sub cycles", t_we - t_b, 1);
      end
      $display("test subtract done");
      for (int i = 0; i < 8; i++) begin
         a = 8'($urandom);
         fv = 8'($urandom);
         w = 8'($urandom);
         s3 = 3'($urandom);
         i_far.mem[a] = fv;
         setws(w, s3);
         ex(crs_pkg::OP_ROTR, i[0], a);
         res = {s3[0], fv[7:1]};
         rdchk("rot w", crs_pkg::OFF_WREG, 32'hFF, i[0] ? w : res);
         chk("rot file", i_far.mem[a], i[0] ? res : fv);
         rdchk("rot flags", crs_pkg::OFF_STATUS, 32'h7, {s3[2:1], fv[0]});
         if (i[0])
            chk("rot cycles", t_we - t_b, 1);
      end
      $display("test rotate done");
      w = 8'($urandom);
      s3 = 3'($urandom);
      setws(w, s3);
      pv = pc;
      tw = t_we;
      tp = t_pop;
      ex(crs_pkg::OP_NONE, 1'b1, 8'h5A);
      rdchk("nop w", crs_pkg::OFF_WREG, 32'hFF, w);
      // expiry still holds its reset value of one here
      rdchk("nop flags", crs_pkg::OFF_STATUS, 32'h7F, {27'h0, 2'b10, s3});
      chk("nop pc", pc, pv);
      chk("nop we", t_we - tw, 0);
      chk("nop pop", t_pop - tp, 0);
      $display("test nop done");
      for (int i = 0; i < 4; i++) begin
         op = i[0] ? crs_pkg::OP_RETLIT : crs_pkg::OP_RETURN;
         pv = 11'($urandom);
         w = 8'($urandom);
         k = 8'($urandom);
         s3 = 3'($urandom);
         push(pv);
         setws(w, s3);
         ex(op, 1'b0, k);
         chk("ret pc", pc, pv);
         rdchk("ret w", crs_pkg::OFF_WREG, 32'hFF, i[0] ? k : w);
         rdchk("ret flags", crs_pkg::OFF_STATUS, 32'h7, s3);
         chk("ret cycles", t_pop - t_b, 2);
         chk("ret depth", i_far.sp, 0);
      end
      $display("test return done");
      for (int j = 0; j < 2; j++) begin
         // no interrupt source is left pending before sleep
         wr(crs_pkg::OFF_INSTR, {16'h0, crs_pkg::OP_SLEEP, 10'h0}, r);
         repeat (12) @(posedge aclk);
         chk("sleep osc", osc_run, 0);
         chk("sleep stop", t_osc - t_b, 1);
         rdchk("sleep flags", crs_pkg::OFF_STATUS, 32'h38, 32'h28);
         wr(crs_pkg::OFF_WREG, 32'h0, r);
         chk("busy write", r, crs_pkg::RESP_SLVERR);
         ext_wake <= (j == 0);
         wdt_wake <= (j == 1);
         for (n = 0; n < 20 && osc_run !== 1'b1; n++)
            @(posedge aclk);
         ext_wake <= 0;
         wdt_wake <= 0;
         chk("wake osc", osc_run, 1);
         idle();
         rdchk("wake expiry", crs_pkg::OFF_STATUS, 32'h30, j << 4);
         ex(crs_pkg::OP_NONE, 1'b0, 8'h0);
      end
      $display("test sleep done");
      summarize();
   end
endmodule
`default_nettype wire
